/* design/sef_pkg.sv */
// Purpose: Shared constants and types for the serial memory front end
// Assumes: One byte per transfer unit, MSB first
// Notes:   Both link ends and the bench use these names
package sef_pkg;
  localparam int DATA_W = 8;
  localparam int ARRAY_BYTES = 16384;
  localparam int ADDR_W = $clog2(ARRAY_BYTES);
  localparam int ID_PAGE_BYTES = 64;
  localparam int ID_OFS_W = $clog2(ID_PAGE_BYTES);
  localparam int HALF_DEF = 4;
  localparam bit CPOL_DEF = 1'b0;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] IDX_INSTR = 2'h0;
  localparam logic [1:0] IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // Positions in the device's system-side synchroniser
  localparam int S_CS = 3;
  localparam int S_ARM = 2;
  localparam int S_RX = 1;
  localparam int S_TX = 0;
  localparam logic [3:0] SYNC_RST = 4'h8;
  typedef enum logic [5:0] {
    SEF_IDLE  = 6'h01,
    SEF_LEAD  = 6'h02,
    SEF_RISE  = 6'h04,
    SEF_FALL  = 6'h08,
    SEF_PAUSE = 6'h10,
    SEF_TAIL  = 6'h20
  } sef_state_e;
endpackage

/* design/sef_if.sv */
// Purpose: Serial link between bus master and memory front end
// Assumes: Master drives sck, cs_b, hold_b and mosi at all times
// Notes:   Data-out line reads low while the memory does not drive it
`timescale 1ns/100ps
interface sef_if;
  logic sck;
  logic cs_b;
  logic hold_b;
  logic mosi;
  logic q_out;
  logic q_oe;
  logic miso;

  assign miso = q_oe ? q_out : 1'b0;

  modport dev (input sck, input cs_b, input hold_b, input mosi, output q_out, output q_oe);
  modport host (output sck, output cs_b, output hold_b, output mosi, input miso);
endinterface

/* design/sef_dev.sv */
// Purpose: Memory-side serial front end: shifts bytes in and out
// Assumes: Link logic runs on the serial clock; user side on CLK_SYS
// Notes:   A reply byte must be staged before its byte boundary
// Function
// [R01] Output changes only on falling clock edges
// [R02] Input captured on rising clock edges
// [R03] Instruction, then address, then data
// [R04] Deselected means output stays high impedance
// [R05] Standby when deselected unless write runs
// [R06] Select low means active, accepting clocks
// [R07] Ignore transfers until first select fall
// [R08] Pause freezes position, keeps device selected
// [R09] Paused: output off, clock and input ignored
// [R10] Pause acts only while selected
// [R11] Master drives every input to level
// [R12] Array of 16384 bytes, 14-bit address
// [R13] Extra 64-byte identification page offset
// [R14] Most significant bit first both ways
// [R15] Idle-low or idle-high clock both allowed
// [R16] Pause edges fall while clock low
// [R17] Deselect while paused resets transfer logic
// [R18] Deselect clears bit and byte counters
// [R19] Output driven only in reply phase
`timescale 1ns/100ps
module sef_dev #(
  parameter int ADDR_W = sef_pkg::ADDR_W
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_B,
  sef_if.dev                                 LINK,
  input  wire logic                          WR_BUSY,
  input  wire logic [sef_pkg::DATA_W-1:0]    TX_DATA,
  input  wire logic                          TX_VALID,
  output logic                               TX_READY,
  output logic [sef_pkg::DATA_W-1:0]         RX_DATA,
  output logic [1:0]                         RX_INDEX,
  output logic                               RX_VALID,
  output logic [ADDR_W-1:0]                  ADDR,
  output logic [sef_pkg::ID_OFS_W-1:0]       ID_OFFSET,
  output logic                               SELECTED,
  output logic                               STANDBY
);
  localparam int DW = sef_pkg::DATA_W;

  // Serial clock domain
  logic          armed_ff;
  logic [2:0]    bit_ff;
  logic [1:0]    byte_idx_ff;
  logic [DW-2:0] sh_in_ff;
  logic [DW-1:0] rx_byte_ff;
  logic [1:0]    rx_idx_ff;
  logic          rx_tog_ff;
  logic [15:0]   addr_ff;
  logic          tx_s1_ff;
  logic          tx_s2_ff;
  logic          tx_seen_ff;
  logic [DW-1:0] sh_out_ff;
  logic          resp_ff;

  // System clock domain
  logic [3:0]    s1_ff;
  logic [3:0]    s2_ff;
  logic          rx_prev_ff;
  logic          rx_vld_ff;
  logic [DW-1:0] rx_data_ff;
  logic [1:0]    rx_index_ff;
  logic [15:0]   addr_sys_ff;
  logic [DW-1:0] tx_hold_ff;
  logic          tx_tog_ff;

  wire           paused;
  wire           live;
  wire           link_rst_b;
  wire           byte_end;
  wire           boundary;
  wire           pending;
  wire           take;
  wire [DW-1:0]  nxt_byte;
  wire [1:0]     nxt_idx;
  wire [3:0]     sync_in;
  wire           rx_evt;
  wire           tx_load;

  assign paused     = ~LINK.hold_b & ~LINK.cs_b;                // see [R10] see [R16]
  assign live       = armed_ff & ~LINK.cs_b & ~paused;          // see [R08] see [R09]
  assign link_rst_b = RST_B & ~LINK.cs_b & armed_ff;            // see [R17] see [R18]
  assign byte_end   = bit_ff == sef_pkg::BIT_LAST;
  assign nxt_byte   = {sh_in_ff, LINK.mosi};                    // see [R14]
  assign nxt_idx    = (byte_idx_ff == sef_pkg::IDX_DATA) ? byte_idx_ff
                                                          : byte_idx_ff + 2'h1;
  // Byte boundary seen at the falling edge after the eighth rising edge
  assign boundary   = (bit_ff == sef_pkg::BIT_FIRST) &&
                      (byte_idx_ff != sef_pkg::IDX_INSTR);      // see [R15]
  assign pending    = tx_s2_ff ^ tx_seen_ff;
  assign take       = live & boundary & pending;

  // Select becomes effective only after a falling select edge
  always_ff @(negedge LINK.cs_b or negedge RST_B)
  begin
    if (!RST_B)
      armed_ff <= 1'b0;
    else
      armed_ff <= 1'b1;                                         // see [R07]
  end

  // Bit and byte position, cleared whenever the device is deselected
  always_ff @(posedge LINK.sck or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      bit_ff      <= sef_pkg::BIT_FIRST;
      byte_idx_ff <= sef_pkg::IDX_INSTR;
      sh_in_ff    <= '0;
    end
    else if (live)
    begin
      bit_ff   <= bit_ff + 3'h1;                                // see [R02]
      sh_in_ff <= nxt_byte[DW-2:0];
      if (byte_end)
        byte_idx_ff <= nxt_idx;                                 // see [R03]
    end
  end

  // Received byte and its index stay stable for the next eight bits
  always_ff @(posedge LINK.sck or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_byte_ff <= sef_pkg::BYTE_RST;
      rx_idx_ff  <= sef_pkg::IDX_INSTR;
      rx_tog_ff  <= 1'b0;
    end
    else if (live && byte_end)
    begin
      rx_byte_ff <= nxt_byte;
      rx_idx_ff  <= byte_idx_ff;
      rx_tog_ff  <= ~rx_tog_ff;
    end
  end

  always_ff @(posedge LINK.sck or negedge RST_B)
  begin
    if (!RST_B)
      addr_ff <= sef_pkg::ADDR_RST;
    else if (live && byte_end && byte_idx_ff == sef_pkg::IDX_ADDR_HI)
      addr_ff[15:8] <= nxt_byte;
    else if (live && byte_end && byte_idx_ff == sef_pkg::IDX_ADDR_LO)
      addr_ff[7:0] <= nxt_byte;
  end

  // Staged reply handshake; survives deselect so no toggle is lost
  always_ff @(negedge LINK.sck or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tx_s1_ff   <= 1'b0;
      tx_s2_ff   <= 1'b0;
      tx_seen_ff <= 1'b0;
    end
    else
    begin
      tx_s1_ff <= tx_tog_ff;
      tx_s2_ff <= tx_s1_ff;
      if (take)
        tx_seen_ff <= ~tx_seen_ff;
    end
  end

  // Reply shifter: at a byte boundary loads a pending reply, between boundaries shifts one bit
  always_ff @(negedge LINK.sck or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      sh_out_ff <= sef_pkg::BYTE_RST;
      resp_ff   <= 1'b0;
    end
    else if (live && boundary)
    begin
      resp_ff <= pending;                                       // see [R19]
      if (pending)
        sh_out_ff <= tx_hold_ff;                                // see [R01]
    end
    else if (live)
      sh_out_ff <= {sh_out_ff[DW-2:0], 1'b0};                   // see [R01] see [R14]
  end

  assign LINK.q_out = sh_out_ff[DW-1];
  assign LINK.q_oe  = resp_ff & live;                           // see [R04] see [R09]

  // Crossing into the system clock
  assign sync_in = {LINK.cs_b, armed_ff, rx_tog_ff, tx_seen_ff};
  assign rx_evt  = s2_ff[sef_pkg::S_RX] ^ rx_prev_ff;
  assign tx_load = TX_VALID & TX_READY;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s1_ff      <= sef_pkg::SYNC_RST;
      s2_ff      <= sef_pkg::SYNC_RST;
      rx_prev_ff <= 1'b0;
      rx_vld_ff  <= 1'b0;
    end
    else
    begin
      s1_ff      <= sync_in;
      s2_ff      <= s1_ff;
      rx_prev_ff <= s2_ff[sef_pkg::S_RX];
      rx_vld_ff  <= rx_evt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_data_ff  <= sef_pkg::BYTE_RST;
      rx_index_ff <= sef_pkg::IDX_INSTR;
      addr_sys_ff <= sef_pkg::ADDR_RST;
    end
    else if (rx_evt)
    begin
      rx_data_ff  <= rx_byte_ff;
      rx_index_ff <= rx_idx_ff;
      addr_sys_ff <= addr_ff;
    end
  end

  // Reply word is held until the link side has taken it
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tx_hold_ff <= sef_pkg::BYTE_RST;
      tx_tog_ff  <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_hold_ff <= TX_DATA;
      tx_tog_ff  <= ~tx_tog_ff;
    end
  end

  assign TX_READY  = tx_tog_ff == s2_ff[sef_pkg::S_TX];
  assign RX_DATA   = rx_data_ff;
  assign RX_INDEX  = rx_index_ff;
  assign RX_VALID  = rx_vld_ff;
  assign ADDR      = addr_sys_ff[ADDR_W-1:0];                   // see [R12]
  assign ID_OFFSET = addr_sys_ff[sef_pkg::ID_OFS_W-1:0];        // see [R13]
  assign SELECTED  = ~s2_ff[sef_pkg::S_CS] & s2_ff[sef_pkg::S_ARM]; // see [R06]
  assign STANDBY   = s2_ff[sef_pkg::S_CS] & ~WR_BUSY;           // see [R05]
endmodule

/* design/sef_host.sv */
// Purpose: Bus master end: makes the serial clock and moves bytes
// Assumes: HALF system cycles per clock half, at least 3
// Notes:   Full duplex; one reply byte per command byte
`timescale 1ns/100ps
module sef_host #(
  parameter int HALF = sef_pkg::HALF_DEF,
  parameter bit CPOL = sef_pkg::CPOL_DEF
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_B,
  sef_if.host                                LINK,
  input  wire logic [sef_pkg::DATA_W-1:0]    CMD_DATA,
  input  wire logic                          CMD_LAST,
  input  wire logic                          CMD_VALID,
  output logic                               CMD_READY,
  input  wire logic                          PAUSE,
  output logic [sef_pkg::DATA_W-1:0]         RSP_DATA,
  output logic                               RSP_VALID,
  output logic                               BUSY
);
  localparam int DW = sef_pkg::DATA_W;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

  sef_pkg::sef_state_e state_ff;
  sef_pkg::sef_state_e nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [2:0]    bit_ff;
  logic          endb_ff;
  logic          last_ff;
  logic [DW-1:0] sh_ff;
  logic [DW-1:0] rx_ff;
  logic [DW-1:0] rsp_ff;
  logic          rsp_vld_ff;
  logic          q_s1_ff;
  logic          q_s2_ff;
  logic          cs_b_ff;
  logic          sck_ff;
  logic          hold_b_ff;

  wire           tick;
  wire           in_idle;
  wire           in_rise;
  wire           in_fall;
  wire           load;
  wire           sample;
  wire           nxt_cs_b;
  wire           nxt_sck;
  wire [DW-1:0]  nxt_rx;

  assign tick    = cnt_ff == CW'(HALF - 1);
  assign in_idle = state_ff == sef_pkg::SEF_IDLE;
  assign in_rise = state_ff == sef_pkg::SEF_RISE;
  assign in_fall = state_ff == sef_pkg::SEF_FALL;
  // Next byte is taken in idle, or with the clock low after the last bit when not pausing
  assign load    = tick & CMD_VALID & (in_idle | (in_fall & endb_ff & ~last_ff & ~PAUSE));
  assign sample  = in_rise & tick;
  assign nxt_rx  = {rx_ff[DW-2:0], q_s2_ff};                    // see [R14]

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sef_pkg::SEF_IDLE:  if (load) nxt_state = sef_pkg::SEF_LEAD;
      sef_pkg::SEF_LEAD:  if (tick) nxt_state = sef_pkg::SEF_RISE;
      sef_pkg::SEF_RISE:  if (tick) nxt_state = sef_pkg::SEF_FALL;
      sef_pkg::SEF_FALL:
        if (PAUSE)
          nxt_state = sef_pkg::SEF_PAUSE;                      // see [R16]
        else if (tick && !endb_ff)
          nxt_state = sef_pkg::SEF_RISE;
        else if (tick && last_ff)
          nxt_state = sef_pkg::SEF_TAIL;
        else if (load)
          nxt_state = sef_pkg::SEF_LEAD;
      sef_pkg::SEF_PAUSE: if (tick && !PAUSE) nxt_state = sef_pkg::SEF_FALL;
      sef_pkg::SEF_TAIL:  if (tick) nxt_state = sef_pkg::SEF_IDLE;
      default:            nxt_state = sef_pkg::SEF_IDLE;
    endcase
  end

  assign nxt_cnt  = (tick || nxt_state != state_ff) ? '0 : cnt_ff + 1'b1;
  assign nxt_cs_b = nxt_state == sef_pkg::SEF_IDLE;             // see [R07] see [R10]
  // Idle level returns only after select is already high
  assign nxt_sck  = (nxt_state == sef_pkg::SEF_RISE) ? 1'b1 :
                    (in_idle && nxt_cs_b) ? CPOL : 1'b0;        // see [R15]

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_ff  <= sef_pkg::SEF_IDLE;
      cnt_ff    <= '0;
      cs_b_ff   <= 1'b1;
      sck_ff    <= CPOL;
      hold_b_ff <= 1'b1;
      q_s1_ff   <= 1'b0;
      q_s2_ff   <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      cs_b_ff   <= nxt_cs_b;
      sck_ff    <= nxt_sck;
      hold_b_ff <= nxt_state != sef_pkg::SEF_PAUSE;             // see [R16]
      q_s1_ff   <= LINK.miso;
      q_s2_ff   <= q_s1_ff;
    end
  end

  // Command shifter: loaded in idle or with the clock low, shifted after a rising edge
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sh_ff   <= sef_pkg::BYTE_RST;
      bit_ff  <= sef_pkg::BIT_FIRST;
      endb_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else if (load)
    begin
      sh_ff   <= CMD_DATA;                                      // see [R03]
      bit_ff  <= sef_pkg::BIT_FIRST;
      endb_ff <= 1'b0;
      last_ff <= CMD_LAST;
    end
    else if (sample)
    begin
      sh_ff   <= {sh_ff[DW-2:0], 1'b0};                         // see [R02] see [R14]
      bit_ff  <= bit_ff + 3'h1;
      endb_ff <= bit_ff == sef_pkg::BIT_LAST;
    end
  end

  // Reply bit sampled late in the high half, long after the falling edge
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_ff      <= sef_pkg::BYTE_RST;
      rsp_ff     <= sef_pkg::BYTE_RST;
      rsp_vld_ff <= 1'b0;
    end
    else
    begin
      rsp_vld_ff <= sample && bit_ff == sef_pkg::BIT_LAST;
      if (sample)
        rx_ff <= nxt_rx;                                        // see [R01]
      if (sample && bit_ff == sef_pkg::BIT_LAST)
        rsp_ff <= nxt_rx;
    end
  end

  assign LINK.cs_b   = cs_b_ff;                                 // see [R11]
  assign LINK.sck    = sck_ff;
  assign LINK.hold_b = hold_b_ff;
  assign LINK.mosi   = sh_ff[DW-1];
  assign CMD_READY   = load;
  assign RSP_DATA    = rsp_ff;
  assign RSP_VALID   = rsp_vld_ff;
  assign BUSY        = ~in_idle;
endmodule

/* verif/sef_props.sv */
// Purpose: Link-level checks between the host end and the memory end
// Assumes: CLK_SYS samples every link line; idle-low clock, four-cycle half
// Notes:   Sees only the shared interface lines
`timescale 1ns/100ps
module sef_props (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic hold_b,
  input wire logic mosi,
  input wire logic q_out,
  input wire logic q_oe
);
  logic       sck_ff;
  logic [3:0] rise_ff;
  wire        rise     = sck && !sck_ff && hold_b;
  wire  [3:0] nxt_rise = cs_b ? 4'h0 : (rise && rise_ff < 4'h8) ? rise_ff + 4'h1 : rise_ff;

  // Counts clock rises of the current selection, saturating after one byte
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sck_ff  <= 1'b0;
      rise_ff <= 4'h0;
    end
    else
    begin
      sck_ff  <= sck;
      rise_ff <= nxt_rise;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  chk_desel_oe: assert property (cs_b |-> !q_oe)
    else $error("output driven while deselected");
  chk_hold_oe: assert property (!hold_b && !cs_b |-> !q_oe)
    else $error("output driven while paused");
  chk_q_falls: assert property ($changed(q_out) && q_oe |-> $fell(sck))
    else $error("output bit moved off a falling clock");
  chk_oe_start: assert property ($rose(q_oe) |-> $fell(sck) || $rose(hold_b))
    else $error("output enabled off a falling clock");
  chk_instr_quiet: assert property (!cs_b && rise_ff < 4'h8 |-> !q_oe)
    else $error("output driven during the instruction byte");
  chk_hold_sck: assert property (!hold_b |-> !sck ##1 (hold_b || !sck))
    else $error("clock moved while paused");
  chk_hold_edge: assert property ($changed(hold_b) |-> !sck && !$past(sck))
    else $error("pause edge while clock high");
  chk_hold_sel: assert property (!hold_b |-> !cs_b)
    else $error("pause while deselected");
  chk_mosi_low: assert property ($changed(mosi) |-> !sck)
    else $error("input bit moved while clock high");
  chk_cs_lead: assert property ($fell(cs_b) |-> (!sck) [*4])
    else $error("clock rose too soon after select");
  chk_cs_idle: assert property ($rose(cs_b) |-> !sck)
    else $error("deselect with clock not idle");
endmodule

/* verif/tb.sv */
// Purpose: Self-checking bench joining host end and memory end
// Assumes: Host makes the serial clock from CLK_SYS, half period four cycles
// Notes:   Random frames with fixed seed plus address corner cases
`timescale 1ns/100ps
module tb;
  logic        clk_sys, rst_b, wr_busy, tx_valid, tx_ready, rx_valid;
  logic        selected, standby, cmd_last, cmd_valid, cmd_ready, pause;
  logic        rsp_valid, busy;
  logic [7:0]  tx_data, rx_data, cmd_data, rsp_data;
  logic [1:0]  rx_index;
  logic [13:0] addr;
  logic [5:0]  id_offset;
  logic        rx_valid_p, rsp_valid_p;
  logic [7:0]  rx_data_p, rsp_data_p;
  integer      seed = 32'h2e1dc7e0;
  int          num_errors = 0;
  int          n_tests = 0;

  sef_if i_sef_if ();
  sef_dev i_sef_dev (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(i_sef_if), .WR_BUSY(wr_busy),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data),
    .RX_INDEX(rx_index), .RX_VALID(rx_valid), .ADDR(addr), .ID_OFFSET(id_offset),
    .SELECTED(selected), .STANDBY(standby));
  sef_host i_sef_host (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(i_sef_if),
    .CMD_DATA(cmd_data), .CMD_LAST(cmd_last), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .PAUSE(pause), .RSP_DATA(rsp_data), .RSP_VALID(rsp_valid), .BUSY(busy));
  sef_props i_sef_props (.CLK_SYS(clk_sys), .RST_B(rst_b), .sck(i_sef_if.sck),
    .cs_b(i_sef_if.cs_b), .hold_b(i_sef_if.hold_b), .mosi(i_sef_if.mosi),
    .q_out(i_sef_if.q_out), .q_oe(i_sef_if.q_oe));

  // Second pair runs the idle-high clock on the same stimulus
  sef_if i_sef_if_p ();
  sef_dev i_sef_dev_p (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(i_sef_if_p), .WR_BUSY(wr_busy),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(), .RX_DATA(rx_data_p), .RX_INDEX(),
    .RX_VALID(rx_valid_p), .ADDR(), .ID_OFFSET(), .SELECTED(), .STANDBY());
  sef_host #(.CPOL(1'b1)) i_sef_host_p (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(i_sef_if_p),
    .CMD_DATA(cmd_data), .CMD_LAST(cmd_last), .CMD_VALID(cmd_valid), .CMD_READY(),
    .PAUSE(pause), .RSP_DATA(rsp_data_p), .RSP_VALID(rsp_valid_p), .BUSY());

  always #50 clk_sys = ~clk_sys;

  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      n_tests++;
      if (got !== exp)
      begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    begin
      cmp_word(what, {15'h0, exp}, {15'h0, got});
    end
  endtask

  task automatic give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  function automatic logic [1:0] exp_idx(input int k);
    return (k > 3) ? 2'h3 : k[1:0];
  endfunction

  function automatic logic [15:0] exp_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] a;
    begin
      a = {hi, lo};
      return {2'h0, a[sef_pkg::ADDR_W-1:0]};
    end
  endfunction

  task automatic do_reset;
    begin
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(negedge clk_sys);
      cmp_flag("selected before select edge", 1'b0, selected);
      cmp_flag("standby after reset", !wr_busy, standby);
      cmp_flag("host busy after reset", 1'b0, busy);
    end
  endtask

  // One selection: n command bytes, replies staged during the previous byte
  task automatic run_frame(input int n, input logic [7:0] hi, input logic [7:0] lo,
                           input bit pz);
    logic [7:0]  cm [0:7];
    logic [7:0]  tx [0:7];
    bit          sk [0:7];
    logic [15:0] ea;
    logic [15:0] er [0:7];
    bit          wb, go;
    int          ci, ri, si, ti, it, pat, ri2, si2;
    begin
      for (int k = 0; k < 8; k++)
      begin
        cm[k] = 8'($random(seed));
        tx[k] = 8'($random(seed));
        sk[k] = ($random(seed) & 3) == 0;
        er[k] = (k == 0 || sk[k]) ? 16'h0 : {8'h0, tx[k]};
      end
      cm[1] = hi;
      cm[2] = lo;
      wb = $random(seed);
      pat = 70 + ($random(seed) & 63);
      ci = 0;
      ri = 0;
      si = 0;
      ri2 = 0;
      si2 = 0;
      ti = 1;
      @(posedge clk_sys);
      wr_busy <= wb;
      for (it = 0; it < 3000 && !(ri == n && si == n && ri2 == n && si2 == n &&
                                  busy === 1'b0); it++)
      begin
        @(negedge clk_sys);
        if (cmd_ready === 1'b1)
          ci++;
        if (rx_valid === 1'b1)
        begin
          cmp_word("received byte", {8'h0, cm[ri]}, {8'h0, rx_data});
          cmp_word("byte index", {14'h0, exp_idx(ri)}, {14'h0, rx_index});
          ri++;
        end
        if (rx_valid_p === 1'b1)
        begin
          cmp_word("idle-high received byte", {8'h0, cm[ri2]}, {8'h0, rx_data_p});
          ri2++;
        end
        if (rsp_valid === 1'b1)
        begin
          cmp_word("reply byte", er[si], {8'h0, rsp_data});
          si++;
        end
        if (rsp_valid_p === 1'b1)
        begin
          cmp_word("idle-high reply byte", er[si2], {8'h0, rsp_data_p});
          si2++;
        end
        if (selected === 1'b1)
          cmp_flag("standby while selected", 1'b0, standby);
        go = 0;
        // A staged reply is given one edge to land before the next is offered
        if (ti < n && selected === 1'b1 && ri >= ti - 1)
        begin
          if (sk[ti])
            ti++;
          else if (tx_ready === 1'b1 && !tx_valid)
            go = 1;
        end
        @(posedge clk_sys);
        cmd_valid <= ci < n;
        cmd_data  <= cm[(ci < n) ? ci : 0];
        cmd_last  <= ci == n - 1;
        tx_valid  <= go;
        tx_data   <= tx[ti];
        pause     <= pz && it >= pat && it < pat + 20;
        if (go)
          ti++;
      end
      if (it >= 3000)
      begin
        num_errors++;
        $display("CHECK FAILED frame completion expected done seen hang");
        give_verdict();
      end
      repeat (4) @(negedge clk_sys);
      cmp_flag("selected after frame", 1'b0, selected);
      cmp_flag("standby after frame", !wb, standby);
      if (n >= 3)
      begin
        ea = exp_addr(hi, lo);
        cmp_word("address", ea, {2'h0, addr});
        cmp_word("page offset", {10'h0, ea[5:0]}, {10'h0, id_offset});
      end
      $display("frame of %0d bytes done", n);
    end
  endtask

  initial
  begin
    int n;
    clk_sys   = 1'b0;
    rst_b     = 1'b0;
    wr_busy   = 1'b0;
    tx_valid  = 1'b0;
    tx_data   = 8'h00;
    cmd_data  = 8'h00;
    cmd_last  = 1'b0;
    cmd_valid = 1'b0;
    pause     = 1'b0;
    do_reset();
    run_frame(4, 8'hff, 8'hff, 1'b0);
    run_frame(1, 8'h00, 8'h00, 1'b0);
    run_frame(3, 8'h40, 8'h00, 1'b1);
    for (int f = 0; f < 10; f++)
    begin
      n = 1 + ($random(seed) & 3) + ($random(seed) & 1);
      run_frame(n, 8'($random(seed)), 8'($random(seed)), n >= 3 && $random(seed) & 1);
      if (f == 5)
        do_reset();
    end
    give_verdict();
  end
endmodule
